// ===== logic/wake_ctl_pkg.sv
// Package for the second I2C control register block.
// Assumes one 25 MHz clock and an async active-low reset.
package wake_ctl_pkg;
  // ----------------------------------------------------------------
  // Register layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL1_RESET = 8'h00;
  localparam int WAKE_BIT = 7;
  localparam int CLK_LVL_BIT = 5;
  localparam int DAT_LVL_BIT = 4;
  localparam int SPEED_BIT = 3;
  localparam int FILTER_BIT = 2;
  localparam logic [7:0] CTL1_WR_MASK = 8'h8c;
  localparam logic [7:0] SHIFT_RELEASE = 8'hff;
  // ----------------------------------------------------------------
  // Status patterns (bit 3 of the pattern is don't care)
  // ----------------------------------------------------------------
  localparam logic [7:0] STS_ADDR = 8'h16;
  localparam logic [7:0] STS_EXT = 8'h22;
  localparam logic [7:0] STS_STOP = 8'h01;
  localparam logic [7:0] STS_IDLE = 8'h00;
  localparam int STS_MASTER_BIT = 7;
  localparam int STS_EXTCODE_BIT = 5;
  localparam int STS_MATCH_BIT = 4;
  localparam int STS_START_BIT = 1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int WAKE_SETTLE_CYCLES = 3;
  typedef enum logic [1:0] {IDLE, ADDRESSED, EXTENDED} bus_phase_t;
endpackage : wake_ctl_pkg

// ===== logic/line_sync_if.sv
// Carrier between the top and its line synchroniser.
// Assumes both ends run on the same clock.
interface line_sync_if;
  logic scl_raw;
  logic sda_raw;
  logic scl_s;
  logic sda_s;
  modport sync (input scl_raw, input sda_raw, output scl_s, output sda_s);
  modport user (output scl_raw, output sda_raw, input scl_s, input sda_s);
endinterface : line_sync_if

// ===== logic/line_sync.sv
// Two-flop synchroniser for the bus clock and data lines.
// Assumes lines are asynchronous to clock.
module line_sync
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Lines
  line_sync_if.sync lines
);
  typedef struct packed
  {
    logic [1:0] meta;
    logic [1:0] stable;
  } sync_state_t;
  sync_state_t s_q;
  sync_state_t s_d;
  always_comb
  begin
    s_d = s_q;
    s_d.meta = {lines.scl_raw, lines.sda_raw};
    s_d.stable = s_q.meta;
  end
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      s_q <= '{meta: 2'h3, stable: 2'h3};
    else
      s_q <= s_d;
  end
  assign lines.scl_s = s_q.stable[1];
  assign lines.sda_s = s_q.stable[0];
endmodule : line_sync

// ===== logic/i2c_wakeup_ctl.sv
// Second I2C control register, wakeup and slave status tracking.
// Assumes a simple byte-wide SFR port with bit-write mask; the bus
// protocol decoder elsewhere supplies address-match and code events.
// Function
// - Register takes bit and byte writes; level monitor bits ignore writes.
// - Bits 5 and 4 report sampled clock and data line levels.
// - Reset clears the register to zero except bits 5 and 4, whose synchroniser resets high.
// - Wakeup cleared without interrupt blocks master until start or stop.
// - Restart with non-matching code gives x110, x010, then 0001 status.
// - Receiving an extension code counts as participating unless a stop comes in the same cycle.
module i2c_wakeup_ctl
  import wake_ctl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic ctl1_wr,
  input wire logic [7:0] ctl1_wmask,
  input wire logic [7:0] ctl1_wdata,
  output logic [7:0] ctl1_rdata,
  input wire logic shift_wr,
  input wire logic [7:0] shift_wdata,
  input wire logic wait_release,
  // Controller context
  input wire logic operation_enable,
  input wire logic stop_interrupt_enable,
  input wire logic stop_mode,
  input wire logic ctl_irq_clear,
  input wire logic master_req,
  input wire logic master_tx,
  input wire logic slave_tx,
  // Bus events from the protocol decoder
  input wire logic start_seen,
  input wire logic stop_seen,
  input wire logic addr_match,
  input wire logic ext_code,
  // Bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  // Outputs
  output logic wake_req,
  output logic match_irq,
  output logic stop_irq,
  output logic master_allowed,
  output logic wait_done,
  output logic [7:0] i2c_status,
  output logic speed_mode,
  output logic filter_en
);
  typedef struct packed
  {
    logic [7:0] ctl;
    logic master_block;
    logic [7:0] status;
    bus_phase_t phase;
    logic wake;
    logic match_irq;
    logic stop_irq;
    logic wait_done;
  } state_t;
  state_t s_q;
  state_t s_d;
  line_sync_if lines ();
  assign lines.scl_raw = scl_in;
  assign lines.sda_raw = sda_in;
  line_sync u_sync
  (
    .clock(clock),
    .resetn(resetn),
    .lines(lines)
  );
  logic busy;
  logic [7:0] wr_val;
  always_comb
  begin
    busy = s_q.status[STS_MASTER_BIT] | s_q.status[STS_EXTCODE_BIT] |
           s_q.status[STS_MATCH_BIT] | s_q.status[STS_START_BIT];
    wr_val = (s_q.ctl & ~ctl1_wmask) | (ctl1_wdata & ctl1_wmask);
  end
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.match_irq = 1'b0;
    s_d.stop_irq = 1'b0;
    s_d.wait_done = 1'b0;
    s_d.wake = 1'b0;
    if (ctl1_wr)
    begin
      // Level monitor bits never latch writes
      if (!operation_enable)
        s_d.ctl[SPEED_BIT] = wr_val[SPEED_BIT];
      if (!operation_enable)
        s_d.ctl[FILTER_BIT] = wr_val[FILTER_BIT];
      if (ctl1_wmask[WAKE_BIT])
      begin
        if (!wr_val[WAKE_BIT] && s_q.ctl[WAKE_BIT] && !ctl_irq_clear)
          s_d.master_block = 1'b1;
        if (!wr_val[WAKE_BIT] || !busy)
          s_d.ctl[WAKE_BIT] = wr_val[WAKE_BIT];
      end
    end
    if (start_seen || stop_seen)
      s_d.master_block = 1'b0;
    // Match interrupt on the next cycle regardless of wakeup
    if (addr_match || ext_code)
      s_d.match_irq = 1'b1;
    if (stop_mode && s_q.ctl[WAKE_BIT] && (addr_match || ext_code))
      s_d.wake = 1'b1;
    if (stop_seen && stop_interrupt_enable && !s_q.ctl[WAKE_BIT])
      s_d.stop_irq = 1'b1;
    if ((master_tx && ((shift_wr && shift_wdata == SHIFT_RELEASE) ||
        wait_release)) || (slave_tx && shift_wr))
      s_d.wait_done = 1'b1;
    unique case (s_q.phase)
      IDLE:
      begin
        if (ext_code)
        begin
          s_d.phase = EXTENDED;
          s_d.status = STS_EXT;
        end
        else if (addr_match)
        begin
          s_d.phase = ADDRESSED;
          s_d.status = STS_ADDR;
        end
      end
      ADDRESSED:
      begin
        if (ext_code)
        begin
          s_d.phase = EXTENDED;
          s_d.status = STS_EXT;
        end
      end
      EXTENDED:
      begin
        s_d.phase = EXTENDED;
      end
      // Fourth code of the two-bit phase is unused
      default:
      begin
        s_d.phase = IDLE;
      end
    endcase
    if (stop_seen)
    begin
      s_d.phase = IDLE;
      s_d.status = STS_STOP;
    end
  end
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q.ctl <= CTL1_RESET;
      s_q.master_block <= 1'b0;
      s_q.status <= STS_IDLE;
      s_q.phase <= IDLE;
      s_q.wake <= 1'b0;
      s_q.match_irq <= 1'b0;
      s_q.stop_irq <= 1'b0;
      s_q.wait_done <= 1'b0;
    end
    else
      s_q <= s_d;
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    ctl1_rdata = s_q.ctl;
    ctl1_rdata[CLK_LVL_BIT] = lines.scl_s;
    ctl1_rdata[DAT_LVL_BIT] = lines.sda_s;
  end
  assign wake_req = s_q.wake;
  assign match_irq = s_q.match_irq;
  assign stop_irq = s_q.stop_irq;
  assign master_allowed = master_req & ~s_q.master_block;
  assign wait_done = s_q.wait_done;
  assign i2c_status = s_q.status;
  assign speed_mode = s_q.ctl[SPEED_BIT];
  assign filter_en = s_q.ctl[FILTER_BIT];
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence match_ev;
    addr_match || ext_code;
  endsequence
  chk_level_bits_ro: assert property (
    ctl1_wr |=> (s_q.ctl[5:4] == 2'b00))
    else $error("level bits latched a write");
  chk_level_follows: assert property (
    ##2 ctl1_rdata[CLK_LVL_BIT] == $past(scl_in, 2))
    else $error("clock level not two-flop sampled");
  chk_match_timing: assert property (
    match_ev |=> match_irq)
    else $error("match interrupt late");
  chk_wake_gate: assert property (
    wake_req |-> $past(s_q.ctl[WAKE_BIT]) && $past(stop_mode))
    else $error("wake without enable");
  chk_stop_masked: assert property (
    (stop_seen && s_q.ctl[WAKE_BIT]) |=> !stop_irq)
    else $error("stop interrupt while wakeup set");
  chk_master_block: assert property (
    (ctl1_wr && ctl1_wmask[WAKE_BIT] && !ctl1_wdata[WAKE_BIT] &&
     s_q.ctl[WAKE_BIT] && !ctl_irq_clear && !start_seen && !stop_seen)
    |=> !master_allowed)
    else $error("master allowed after wakeup cleared");
  chk_ext_status: assert property (
    (ext_code && !stop_seen) |=> i2c_status == STS_EXT)
    else $error("extension status wrong");
  chk_stop_status: assert property (
    stop_seen |=> i2c_status == STS_STOP)
    else $error("stop status wrong");
  chk_ext_sticks: assert property (
    (s_q.phase == EXTENDED && !stop_seen) |=> s_q.phase == EXTENDED)
    else $error("left extension participation");
  chk_slave_release: assert property (
    (slave_tx && !master_tx && wait_release && !shift_wr) |=> !wait_done)
    else $error("slave wait released by release bit");
endmodule : i2c_wakeup_ctl

// ===== tb/bus_peer.sv
// Far-side bus peer: line levels and decoded bus events.
// Assumes lines idle high through the bus pull-ups.
module bus_peer
(
  // Clock
  input wire logic clock,
  // Lines and events {start, stop, match, code}
  output logic scl,
  output logic sda,
  output logic [3:0] evs
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    evs = 4'h0;
  end
  // ----------------------------------------------------------------
  // Link clock runs only inside a frame, 320 ns period
  // ----------------------------------------------------------------
  task frame(input int bits);
    // Line edges kept off the rising edge of clock
    @(negedge clock);
    repeat (bits)
    begin
      #160 scl = 1'b0;
      sda = 1'($urandom);
      #160 scl = 1'b1;
    end
    sda = 1'b1;
    @(posedge clock);
  endtask : frame
  task lines(input logic c, input logic d);
    @(negedge clock);
    scl = c;
    sda = d;
    @(posedge clock);
  endtask : lines
  task pulse(input logic [3:0] e);
    @(posedge clock);
    evs <= e;
    @(posedge clock);
    evs <= 4'h0;
  endtask : pulse
endmodule : bus_peer

// ===== tb/i2c_wakeup_control_status_bench.sv
// Bench for the second control register, wakeup and status block.
// Assumes bus_peer supplies the lines and decoded bus events.
module i2c_wakeup_control_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic resetn;
  logic ctl1_wr, shift_wr, wait_release;
  logic [7:0] ctl1_wmask, ctl1_wdata;
  logic [7:0] shift_wdata, ctl1_rdata, i2c_status;
  logic operation_enable, stop_interrupt_enable;
  logic stop_mode, ctl_irq_clear, master_req;
  logic master_tx, slave_tx, scl, sda;
  logic wake_req, match_irq, stop_irq, master_allowed, wait_done;
  logic speed_mode, filter_en;
  logic [3:0] evs;
  logic [3:0] exp_q[$];
  int bad_count = 0;
  int compares = 0;
  always #20 clock = ~clock;
  bus_peer peer (.clock(clock), .scl(scl), .sda(sda), .evs(evs));
  i2c_wakeup_ctl DUT (.clock(clock), .resetn(resetn), .ctl1_wr(ctl1_wr),
    .ctl1_wmask(ctl1_wmask), .ctl1_wdata(ctl1_wdata),
    .ctl1_rdata(ctl1_rdata), .shift_wr(shift_wr),
    .shift_wdata(shift_wdata), .wait_release(wait_release),
    .operation_enable(operation_enable),
    .stop_interrupt_enable(stop_interrupt_enable),
    .stop_mode(stop_mode), .ctl_irq_clear(ctl_irq_clear),
    .master_req(master_req), .master_tx(master_tx),
    .slave_tx(slave_tx), .start_seen(evs[3]), .stop_seen(evs[2]),
    .addr_match(evs[1]), .ext_code(evs[0]), .scl_in(scl), .sda_in(sda),
    .wake_req(wake_req), .match_irq(match_irq), .stop_irq(stop_irq),
    .master_allowed(master_allowed), .wait_done(wait_done),
    .i2c_status(i2c_status), .speed_mode(speed_mode),
    .filter_en(filter_en));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task chk(input string n, input logic [7:0] e);
    @(negedge clock);
    cmp(n, e, n == "status" ? i2c_status : ctl1_rdata);
    // Return on a rising edge so callers drive there
    @(posedge clock);
  endtask : chk
  task wr(input logic [7:0] m, input logic [7:0] d);
    @(posedge clock);
    ctl1_wr <= 1'b1;
    ctl1_wmask <= m;
    ctl1_wdata <= d;
    @(posedge clock);
    ctl1_wr <= 1'b0;
  endtask : wr
  task sh(input logic [7:0] d, input logic rel);
    @(posedge clock);
    shift_wr <= ~rel;
    shift_wdata <= d;
    wait_release <= rel;
    @(posedge clock);
    shift_wr <= 1'b0;
    wait_release <= 1'b0;
  endtask : sh
  task tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // Pulses {wake, match, stop, wait} against the oldest note
  always @(posedge clock)
    if (resetn && (wake_req | match_irq | stop_irq | wait_done))
      cmp("pulses", exp_q.size() ? exp_q.pop_front() : 4'h0,
        {wake_req, match_irq, stop_irq, wait_done});
  initial
  begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    resetn <= 1'b0;
    {ctl1_wr, shift_wr, wait_release, stop_mode} <= 4'h0;
    {operation_enable, stop_interrupt_enable, ctl_irq_clear} <= 3'h0;
    {master_req, master_tx, slave_tx} <= 3'h0;
    {ctl1_wmask, ctl1_wdata, shift_wdata} <= 24'h000000;
    void'($urandom(32'h54b56432));
    tick(6);
    resetn <= 1'b1;
    tick(3);
    chk("ctl1", 8'h30);
    wr(8'hff, 8'hff);
    chk("ctl1", 8'hbc);
    cmp("modes", 8'h03, {6'h0, speed_mode, filter_en});
    // Mid-run reset must drop every stored control bit while the level bits resync high
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    tick(1);
    chk("ctl1", 8'h30);
    cmp("modes", 8'h00, {6'h0, speed_mode, filter_en});
    wr(8'hff, 8'hff);
    chk("ctl1", 8'hbc);
    wr(8'h80, 8'h00);
    chk("ctl1", 8'h3c);
    operation_enable <= 1'b1;
    wr(8'hff, 8'h00);
    chk("ctl1", 8'h3c);
    operation_enable <= 1'b0;
    wr(8'h0c, 8'h00);
    chk("ctl1", 8'h30);
    peer.lines(1'b0, 1'b1);
    tick(3);
    chk("ctl1", 8'h10);
    peer.lines(1'b1, 1'b0);
    tick(3);
    chk("ctl1", 8'h20);
    peer.lines(1'b1, 1'b1);
    $display("register and line tests done");
    stop_interrupt_enable <= 1'b1;
    peer.frame(9);
    exp_q.push_back(4'b0100);
    peer.pulse(4'b0010);
    chk("status", 8'h16);
    wr(8'h80, 8'h80);
    chk("ctl1", 8'h30);
    exp_q.push_back(4'b0100);
    peer.pulse(4'b0001);
    chk("status", 8'h22);
    exp_q.push_back(4'b0010);
    peer.pulse(4'b0100);
    chk("status", 8'h01);
    $display("restart status test done");
    wr(8'h80, 8'h80);
    tick(3);
    stop_mode <= 1'b1;
    exp_q.push_back(4'b1100);
    peer.pulse(4'b0010);
    stop_mode <= 1'b0;
    peer.pulse(4'b0100);
    master_req <= 1'b1;
    wr(8'h80, 8'h00);
    tick(2);
    cmp("master", 8'h00, {7'h0, master_allowed});
    peer.pulse(4'b1000);
    tick(1);
    cmp("master", 8'h01, {7'h0, master_allowed});
    // Clear that comes from the controller interrupt keeps master usable
    wr(8'h80, 8'h80);
    ctl_irq_clear <= 1'b1;
    wr(8'h80, 8'h00);
    ctl_irq_clear <= 1'b0;
    tick(1);
    cmp("master", 8'h01, {7'h0, master_allowed});
    $display("wakeup test done");
    master_tx <= 1'b1;
    exp_q.push_back(4'b0001);
    sh(8'hff, 1'b0);
    exp_q.push_back(4'b0001);
    sh(8'h00, 1'b1);
    master_tx <= 1'b0;
    slave_tx <= 1'b1;
    sh(8'h00, 1'b1);
    exp_q.push_back(4'b0001);
    sh(8'($urandom), 1'b0);
    slave_tx <= 1'b0;
    tick(4);
    cmp("notes left", 8'h00, 8'(exp_q.size()));
    $display("wait release test done");
    tally_and_finish();
  end
endmodule : i2c_wakeup_control_status_bench
